/* File: core/tic_pkg.sv */
// shared constants for the thermal supervision and interrupt controller
package tic_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [5:0] TIC_IDX_POWER_MGMT_THERMAL = 6'h0B;
    localparam logic [5:0] TIC_IDX_IRQ_STATUS = 6'h1A;
    localparam logic [5:0] TIC_IDX_IRQ_MASK = 6'h1B;
    localparam logic [5:0] TIC_IDX_IRQ_SOURCE_POLARITY = 6'h1C;
    localparam logic [5:0] TIC_IDX_IRQ_PIN_CONTROL = 6'h1D;

    // avalon byte address width and register widths
    localparam int TIC_ADDR_W = 8;
    localparam int TIC_DATA_W = 32;
    localparam int TIC_REG_W = 16;

    // power_mgmt_thermal fields
    localparam int TIC_BIT_THERMAL_CUTOFF_ENABLE = 8;
    localparam int TIC_BIT_TEMP_SENSOR_ENABLE = 7;
    localparam int TIC_BIT_TEMP_STATUS = 6;

    // irq_status and irq_mask share one layout
    localparam int TIC_BIT_SEQUENCER_DONE = 2;
    localparam int TIC_BIT_THERMAL_EVENT = 0;

    // irq_source_polarity field
    localparam int TIC_BIT_THERMAL_EVENT_INVERT = 0;

    // irq_pin_control fields
    localparam int TIC_BIT_IRQ_PIN_POLARITY = 15;
    localparam int TIC_BIT_IRQ_PIN_OPEN_DRAIN = 0;

    // values after reset
    localparam logic TIC_RST_THERMAL_CUTOFF_ENABLE = 1'b1;
    localparam logic TIC_RST_TEMP_SENSOR_ENABLE = 1'b1;
    localparam logic TIC_RST_SEQUENCER_DONE_MASK = 1'b1;
    localparam logic TIC_RST_THERMAL_EVENT_MASK = 1'b0;
    localparam logic TIC_RST_THERMAL_EVENT_INVERT = 1'b0;
    localparam logic TIC_RST_IRQ_PIN_POLARITY = 1'b0;
    localparam logic TIC_RST_IRQ_PIN_OPEN_DRAIN = 1'b0;
    localparam logic TIC_RST_FLAG = 1'b0;

    // synchroniser depth for the sensor comparator input
    localparam int TIC_SYNC_STAGES = 2;

    // bus handshake phase
    typedef enum logic {
        TIC_BUS_IDLE,
        TIC_BUS_ACK
    } tic_bus_e;

endpackage

/* File: core/tic_sync.sv */
// two-flop level synchroniser for inputs from outside the clock domain
module tic_sync
    import tic_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic [TIC_SYNC_STAGES-1:0] stage_reg;
            // the first stage feeds only the second stage
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    stage_reg <= '0;
                end
                else if (ce)
                begin
                    stage_reg <= {stage_reg[TIC_SYNC_STAGES-2:0], async_in[gi]};
                end
            end
            assign sync_out[gi] = stage_reg[TIC_SYNC_STAGES-1];
        end
    endgenerate

endmodule

/* File: core/tic_irq_ctrl.sv */
// thermal supervision and interrupt controller with avalon-mm register slave
//
// Added by the designer: the Avalon-MM interface to the registers.
module tic_irq_ctrl
    import tic_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [TIC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [TIC_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [TIC_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic over_temp_async,
    input wire logic sequencer_done,
    output logic temp_sensor_enable,
    output logic speaker_disable,
    output logic irq,
    output logic irq_pin_out,
    output logic irq_pin_oe
);

    typedef struct packed {
        tic_bus_e bus_phase;
        logic waitrequest;
        logic [TIC_DATA_W-1:0] readdata;
        logic thermal_cutoff_enable;
        logic temp_sensor_enable;
        logic temp_status;
        logic thermal_event_flag;
        logic sequencer_done_flag;
        logic thermal_event_mask;
        logic sequencer_done_mask;
        logic thermal_event_invert;
        logic irq_pin_polarity;
        logic irq_pin_open_drain;
        logic speaker_disable;
        logic irq;
        logic irq_pin_out;
        logic irq_pin_oe;
    } tic_state_s;

    tic_state_s state_reg;
    tic_state_s state_next;

    logic over_temp_sync;

    tic_sync #(
        .WIDTH(1)
    ) u_temp_sync (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .async_in(over_temp_async),
        .sync_out(over_temp_sync)
    );

    // register index decode; low two address bits must be zero for a hit
    logic [5:0] reg_idx;
    logic aligned;
    logic bus_req;
    logic [TIC_REG_W-1:0] wr_mask;
    logic [TIC_REG_W-1:0] wr_bits;

    assign reg_idx = avs_address[TIC_ADDR_W-1:2];
    assign aligned = (avs_address[1:0] == 2'h0);
    assign bus_req = avs_read | avs_write;
    assign wr_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_bits = avs_writedata[TIC_REG_W-1:0] & wr_mask;

    // read view of each register; unused bits read as zero
    function automatic logic [TIC_REG_W-1:0] read_view(
        input tic_state_s s,
        input logic [5:0] idx
    );
        logic [TIC_REG_W-1:0] v;
        v = '0;
        case (idx)
            TIC_IDX_POWER_MGMT_THERMAL:
            begin
                v[TIC_BIT_THERMAL_CUTOFF_ENABLE] = s.thermal_cutoff_enable;
                v[TIC_BIT_TEMP_SENSOR_ENABLE] = s.temp_sensor_enable;
                v[TIC_BIT_TEMP_STATUS] = s.temp_status;
            end
            TIC_IDX_IRQ_STATUS:
            begin
                v[TIC_BIT_THERMAL_EVENT] = s.thermal_event_flag;
                v[TIC_BIT_SEQUENCER_DONE] = s.sequencer_done_flag;
            end
            TIC_IDX_IRQ_MASK:
            begin
                v[TIC_BIT_THERMAL_EVENT] = s.thermal_event_mask;
                v[TIC_BIT_SEQUENCER_DONE] = s.sequencer_done_mask;
            end
            TIC_IDX_IRQ_SOURCE_POLARITY:
            begin
                v[TIC_BIT_THERMAL_EVENT_INVERT] = s.thermal_event_invert;
            end
            TIC_IDX_IRQ_PIN_CONTROL:
            begin
                v[TIC_BIT_IRQ_PIN_POLARITY] = s.irq_pin_polarity;
                v[TIC_BIT_IRQ_PIN_OPEN_DRAIN] = s.irq_pin_open_drain;
            end
            default:
            begin
                v = '0;
            end
        endcase
        return v;
    endfunction

    always_comb
    begin
        logic write_now;
        logic hot;
        logic thermal_set;
        logic seq_set;
        logic thermal_clr;
        logic seq_clr;
        logic irq_active;
        logic pin_level;

        state_next = state_reg;
        write_now = 1'b0;
        hot = 1'b0;
        thermal_set = 1'b0;
        seq_set = 1'b0;
        thermal_clr = 1'b0;
        seq_clr = 1'b0;
        irq_active = 1'b0;
        pin_level = 1'b0;

        // bus handshake: a request is taken only while ce is high, but once
        // acknowledged it completes even if ce drops, so no write is lost
        case (state_reg.bus_phase)
            TIC_BUS_IDLE:
            begin
                state_next.waitrequest = 1'b1;
                if (ce && bus_req)
                begin
                    state_next.bus_phase = TIC_BUS_ACK;
                    state_next.waitrequest = 1'b0;
                    state_next.readdata = '0;
                    if (avs_read && aligned)
                    begin
                        state_next.readdata[TIC_REG_W-1:0] = read_view(state_reg, reg_idx);
                    end
                end
            end
            TIC_BUS_ACK:
            begin
                // master samples waitrequest low at this edge; write lands here
                write_now = avs_write && aligned;
                state_next.bus_phase = TIC_BUS_IDLE;
                state_next.waitrequest = 1'b1;
            end
            default:
            begin
                state_next.bus_phase = TIC_BUS_IDLE;
                state_next.waitrequest = 1'b1;
            end
        endcase

        // configuration writes
        if (write_now)
        begin
            case (reg_idx)
                TIC_IDX_POWER_MGMT_THERMAL:
                begin
                    if (wr_mask[TIC_BIT_THERMAL_CUTOFF_ENABLE])
                    begin
                        state_next.thermal_cutoff_enable =
                            wr_bits[TIC_BIT_THERMAL_CUTOFF_ENABLE];
                    end
                    if (wr_mask[TIC_BIT_TEMP_SENSOR_ENABLE])
                    begin
                        state_next.temp_sensor_enable = wr_bits[TIC_BIT_TEMP_SENSOR_ENABLE];
                    end
                end
                TIC_IDX_IRQ_STATUS:
                begin
                    thermal_clr = wr_bits[TIC_BIT_THERMAL_EVENT];
                    seq_clr = wr_bits[TIC_BIT_SEQUENCER_DONE];
                end
                TIC_IDX_IRQ_MASK:
                begin
                    if (wr_mask[TIC_BIT_THERMAL_EVENT])
                    begin
                        state_next.thermal_event_mask = wr_bits[TIC_BIT_THERMAL_EVENT];
                    end
                    if (wr_mask[TIC_BIT_SEQUENCER_DONE])
                    begin
                        state_next.sequencer_done_mask = wr_bits[TIC_BIT_SEQUENCER_DONE];
                    end
                end
                TIC_IDX_IRQ_SOURCE_POLARITY:
                begin
                    if (wr_mask[TIC_BIT_THERMAL_EVENT_INVERT])
                    begin
                        state_next.thermal_event_invert =
                            wr_bits[TIC_BIT_THERMAL_EVENT_INVERT];
                    end
                end
                TIC_IDX_IRQ_PIN_CONTROL:
                begin
                    if (wr_mask[TIC_BIT_IRQ_PIN_POLARITY])
                    begin
                        state_next.irq_pin_polarity = wr_bits[TIC_BIT_IRQ_PIN_POLARITY];
                    end
                    if (wr_mask[TIC_BIT_IRQ_PIN_OPEN_DRAIN])
                    begin
                        state_next.irq_pin_open_drain = wr_bits[TIC_BIT_IRQ_PIN_OPEN_DRAIN];
                    end
                end
                default:
                begin
                    // unmapped write is accepted and dropped
                    write_now = 1'b0;
                end
            endcase
        end

        // source sampling freezes with ce; a disabled sensor reports nothing
        if (ce)
        begin
            hot = state_reg.temp_sensor_enable & over_temp_sync;
            state_next.temp_status = hot;
            // the invert bit also needs a live sensor, otherwise a disabled
            // sensor would look like a permanent normal-temperature event
            thermal_set = state_reg.temp_sensor_enable
                & (over_temp_sync ^ state_reg.thermal_event_invert);
            seq_set = sequencer_done;
        end

        // level-sampled sticky flags; set wins over a same-cycle clear
        // only two sources exist; other status bits read zero
        state_next.thermal_event_flag =
            (state_reg.thermal_event_flag & ~thermal_clr) | thermal_set;
        state_next.sequencer_done_flag =
            (state_reg.sequencer_done_flag & ~seq_clr) | seq_set;

        // speaker cutoff follows the live over-temperature level
        state_next.speaker_disable = state_next.thermal_cutoff_enable
            & state_next.temp_sensor_enable & state_next.temp_status;

        // outputs are derived from next state so every output is a flop
        irq_active = (state_next.thermal_event_flag & ~state_next.thermal_event_mask)
            | (state_next.sequencer_done_flag & ~state_next.sequencer_done_mask);
        state_next.irq = irq_active;

        // pin level: active low unless the polarity bit is set
        pin_level = state_next.irq_pin_polarity ? irq_active : ~irq_active;
        if (state_next.irq_pin_open_drain)
        begin
            // open drain: release for 1, pull low for 0
            state_next.irq_pin_out = 1'b0;
            state_next.irq_pin_oe = ~pin_level;
        end
        else
        begin
            state_next.irq_pin_out = pin_level;
            state_next.irq_pin_oe = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg.bus_phase <= TIC_BUS_IDLE;
            state_reg.waitrequest <= 1'b1;
            state_reg.readdata <= '0;
            state_reg.thermal_cutoff_enable <= TIC_RST_THERMAL_CUTOFF_ENABLE;
            state_reg.temp_sensor_enable <= TIC_RST_TEMP_SENSOR_ENABLE;
            state_reg.temp_status <= TIC_RST_FLAG;
            state_reg.thermal_event_flag <= TIC_RST_FLAG;
            state_reg.sequencer_done_flag <= TIC_RST_FLAG;
            state_reg.thermal_event_mask <= TIC_RST_THERMAL_EVENT_MASK;
            state_reg.sequencer_done_mask <= TIC_RST_SEQUENCER_DONE_MASK;
            state_reg.thermal_event_invert <= TIC_RST_THERMAL_EVENT_INVERT;
            state_reg.irq_pin_polarity <= TIC_RST_IRQ_PIN_POLARITY;
            state_reg.irq_pin_open_drain <= TIC_RST_IRQ_PIN_OPEN_DRAIN;
            state_reg.speaker_disable <= 1'b0;
            state_reg.irq <= 1'b0;
            // inactive active-low pin drives high in push-pull mode
            state_reg.irq_pin_out <= 1'b1;
            state_reg.irq_pin_oe <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata = state_reg.readdata;
    assign avs_waitrequest = state_reg.waitrequest;
    assign temp_sensor_enable = state_reg.temp_sensor_enable;
    assign speaker_disable = state_reg.speaker_disable;
    assign irq = state_reg.irq;
    assign irq_pin_out = state_reg.irq_pin_out;
    assign irq_pin_oe = state_reg.irq_pin_oe;

endmodule

/* File: testbench/tic_irq_ctrl_monitor.sv */
// port-level assertions for the thermal interrupt controller
module tic_irq_ctrl_monitor
    import tic_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [TIC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [TIC_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [TIC_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic over_temp_async,
    input wire logic sequencer_done,
    input wire logic temp_sensor_enable,
    input wire logic speaker_disable,
    input wire logic irq,
    input wire logic irq_pin_out,
    input wire logic irq_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    a_od_release: assert property (!irq_pin_oe |-> !irq_pin_out)
        else $error("released pin is not driven low");
    a_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest && ce
        |=> !avs_waitrequest)
        else $error("taken request not answered next cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_no_take: assert property (!(ce && (avs_read || avs_write)) && avs_waitrequest
        |=> avs_waitrequest)
        else $error("answer without a taken request");
    a_speaker_sensor: assert property (speaker_disable |-> temp_sensor_enable)
        else $error("speaker cut off with sensor disabled");
    a_speaker_delay: assert property (speaker_disable && $past(ce)
        |-> $past(over_temp_async, 3))
        else $error("speaker cut off without over-temperature");
    a_pin_follow: assert property ($changed(irq)
        |-> $changed(irq_pin_out) || $changed(irq_pin_oe))
        else $error("pin did not follow interrupt");
    a_reset_values: assert property (!$past(nrst)
        |-> temp_sensor_enable && !speaker_disable && !irq && irq_pin_out && irq_pin_oe)
        else $error("outputs wrong after reset");
    a_irq_drop_write: assert property ($fell(irq)
        |-> $past(avs_write) && !$past(avs_waitrequest))
        else $error("interrupt dropped without a register write");
endmodule

bind tic_irq_ctrl tic_irq_ctrl_monitor u_mon (.mclk(mclk), .nrst(nrst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .over_temp_async(over_temp_async), .sequencer_done(sequencer_done),
    .temp_sensor_enable(temp_sensor_enable), .speaker_disable(speaker_disable),
    .irq(irq), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));

/* File: testbench/tic_host_pin.sv */
// host side of the interrupt pin: pull-up resistor and the line it sees
module tic_host_pin
(
    input wire logic irq_pin_out,
    input wire logic irq_pin_oe,
    output logic irq_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pin floats up through the pull-up
    assign irq_line = irq_pin_oe ? irq_pin_out : 1'b1;
endmodule

/* File: testbench/tic_irq_ctrl_tb.sv */
// self-checking bench for the thermal interrupt controller
module tic_irq_ctrl_tb
    import tic_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [TIC_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [TIC_DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [TIC_DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic over_temp_async = 1'b0;
    logic sequencer_done = 1'b0;
    logic temp_sensor_enable, speaker_disable, irq, irq_pin_out, irq_pin_oe, irq_line;
    logic [15:0] rd;
    int n_fail = 0;
    int check_count = 0;

    // the host keeps the system clock running for the whole run
    always #4 mclk = ~mclk;

    tic_irq_ctrl uut (.mclk(mclk), .nrst(nrst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .over_temp_async(over_temp_async),
        .sequencer_done(sequencer_done), .temp_sensor_enable(temp_sensor_enable),
        .speaker_disable(speaker_disable), .irq(irq), .irq_pin_out(irq_pin_out),
        .irq_pin_oe(irq_pin_oe));
    tic_host_pin u_host (.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .irq_line(irq_line));

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        check16({15'h0000, got}, {15'h0000, exp});
    endtask

    // outputs are looked at on the falling edge, where they have settled
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic bus_xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, wd};
        avs_write <= wr;
        avs_read <= !wr;
        // read right at the edge, before the design updates it: its sampled value
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        rd = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic reg_check(input logic [5:0] idx, input logic [15:0] exp);
        bus_xfer(1'b0, idx, 16'h0000);
        check16(rd, exp);
    endtask

    task automatic seq_pulse();
        @(posedge mclk);
        sequencer_done <= 1'b1;
        @(posedge mclk);
        sequencer_done <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic t_reset();
        reg_check(TIC_IDX_POWER_MGMT_THERMAL, 16'h0180);
        reg_check(TIC_IDX_IRQ_STATUS, 16'h0000);
        reg_check(TIC_IDX_IRQ_MASK, 16'h0004);
        reg_check(TIC_IDX_IRQ_SOURCE_POLARITY, 16'h0000);
        reg_check(TIC_IDX_IRQ_PIN_CONTROL, 16'h0000);
        @(negedge mclk);
        check1(temp_sensor_enable, 1'b1);
        check1(irq_line, 1'b1);
        bus_xfer(1'b1, 6'h3F, 16'hFFFF);
        reg_check(6'h3F, 16'h0000);
        // only the upper byte lane is enabled, so the open-drain bit must not land
        @(posedge mclk);
        avs_byteenable <= 4'h2;
        bus_xfer(1'b1, TIC_IDX_IRQ_PIN_CONTROL, 16'h8001);
        avs_byteenable <= 4'hF;
        reg_check(TIC_IDX_IRQ_PIN_CONTROL, 16'h8000);
        bus_xfer(1'b1, TIC_IDX_IRQ_PIN_CONTROL, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_seq();
        bus_xfer(1'b1, TIC_IDX_IRQ_MASK, 16'h0000);
        seq_pulse();
        check1(irq, 1'b1);
        check1(irq_line, 1'b0);
        tick(5);
        reg_check(TIC_IDX_IRQ_STATUS, 16'h0004);
        bus_xfer(1'b1, TIC_IDX_IRQ_STATUS, 16'h0001);
        @(negedge mclk);
        check1(irq, 1'b1);
        bus_xfer(1'b1, TIC_IDX_IRQ_STATUS, 16'h0004);
        @(negedge mclk);
        check1(irq, 1'b0);
        check1(irq_line, 1'b1);
        // a set in the same cycle as the clear must win
        @(posedge mclk);
        sequencer_done <= 1'b1;
        bus_xfer(1'b1, TIC_IDX_IRQ_STATUS, 16'h0004);
        sequencer_done <= 1'b0;
        reg_check(TIC_IDX_IRQ_STATUS, 16'h0004);
        bus_xfer(1'b1, TIC_IDX_IRQ_MASK, 16'h0004);
        @(negedge mclk);
        check1(irq, 1'b0);
        bus_xfer(1'b1, TIC_IDX_IRQ_STATUS, 16'h0004);
        seq_pulse();
        check1(irq, 1'b0);
        reg_check(TIC_IDX_IRQ_STATUS, 16'h0004);
        bus_xfer(1'b1, TIC_IDX_IRQ_STATUS, 16'h0004);
        $display("test sequencer done");
    endtask

    task automatic t_thermal();
        @(posedge mclk);
        over_temp_async <= 1'b1;
        tick(4);
        check1(speaker_disable, 1'b1);
        check1(irq, 1'b1);
        reg_check(TIC_IDX_POWER_MGMT_THERMAL, 16'h01C0);
        bus_xfer(1'b1, TIC_IDX_POWER_MGMT_THERMAL, 16'h0080);
        tick(1);
        check1(speaker_disable, 1'b0);
        bus_xfer(1'b1, TIC_IDX_POWER_MGMT_THERMAL, 16'h0100);
        tick(1);
        check1(temp_sensor_enable, 1'b0);
        check1(speaker_disable, 1'b0);
        bus_xfer(1'b1, TIC_IDX_IRQ_STATUS, 16'h0001);
        tick(4);
        reg_check(TIC_IDX_IRQ_STATUS, 16'h0000);
        reg_check(TIC_IDX_POWER_MGMT_THERMAL, 16'h0100);
        bus_xfer(1'b1, TIC_IDX_POWER_MGMT_THERMAL, 16'h01C0);
        over_temp_async <= 1'b0;
        tick(6);
        check1(speaker_disable, 1'b0);
        reg_check(TIC_IDX_POWER_MGMT_THERMAL, 16'h0180);
        reg_check(TIC_IDX_IRQ_STATUS, 16'h0001);
        @(negedge mclk);
        check1(irq, 1'b1);
        bus_xfer(1'b1, TIC_IDX_IRQ_STATUS, 16'h0001);
        @(negedge mclk);
        check1(irq, 1'b0);
        $display("test thermal done");
    endtask

    task automatic t_invert();
        bus_xfer(1'b1, TIC_IDX_IRQ_SOURCE_POLARITY, 16'h0001);
        tick(1);
        check1(irq, 1'b1);
        reg_check(TIC_IDX_IRQ_STATUS, 16'h0001);
        bus_xfer(1'b1, TIC_IDX_IRQ_MASK, 16'h0005);
        @(negedge mclk);
        check1(irq, 1'b0);
        bus_xfer(1'b1, TIC_IDX_IRQ_SOURCE_POLARITY, 16'h0000);
        bus_xfer(1'b1, TIC_IDX_IRQ_STATUS, 16'h0001);
        reg_check(TIC_IDX_IRQ_STATUS, 16'h0000);
        $display("test invert done");
    endtask

    task automatic t_pin();
        logic [15:0] cfg [4] = '{16'h0000, 16'h8000, 16'h0001, 16'h8001};
        bus_xfer(1'b1, TIC_IDX_IRQ_MASK, 16'h0001);
        foreach (cfg[i])
        begin
            bus_xfer(1'b1, TIC_IDX_IRQ_PIN_CONTROL, cfg[i]);
            seq_pulse();
            check1(irq_line, cfg[i][15]);
            check1(irq_pin_oe, !(cfg[i][0] && cfg[i][15]));
            bus_xfer(1'b1, TIC_IDX_IRQ_STATUS, 16'h0004);
            @(negedge mclk);
            check1(irq_line, !cfg[i][15]);
            check1(irq_pin_oe, !(cfg[i][0] && !cfg[i][15]));
        end
        reg_check(TIC_IDX_IRQ_PIN_CONTROL, 16'h8001);
        $display("test pin done");
    endtask

    // with the clock held off by ce nothing may be detected
    task automatic t_hold();
        @(posedge mclk);
        ce <= 1'b0;
        sequencer_done <= 1'b1;
        tick(3);
        check1(irq, 1'b0);
        @(posedge mclk);
        sequencer_done <= 1'b0;
        ce <= 1'b1;
        reg_check(TIC_IDX_IRQ_STATUS, 16'h0000);
        $display("test hold done");
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_seq();
        t_thermal();
        t_invert();
        t_pin();
        t_hold();
        print_verdict();
    end

    // the tests need well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
